// ---- wide_timer_cfg.svh ----
// Offsets, field positions, reset values and answer codes of the wide timer.
// Assumes a 32-bit AXI4-Lite register port, one register per aligned word.
// Functional notes
// - Mode field 7:5 picks count clock source
// - Prescaler divides source by 1, 4, 16, 64
// - Field 2:0 picks counter bit 8..15 for events
// - Edge select: rising default, or falling
// - Sixteen-bit counter, increments only, by one
// - Store instruction loads initial count value
// - Load instruction reads current count value
// - Rising, bit 8: events at 0x100, 0x300, then 0x500
// - Falling, bit 8: events at 0x200, 0x400, 0x600
// - After restart, next event on zero-to-one
`ifndef WIDE_TIMER_CFG_SVH
`define WIDE_TIMER_CFG_SVH
`define MODE_IDX 8'h06
`define COUNT_IDX 8'h07
`define CTRL_IDX 8'h08
`define STAT_IDX 8'h09
`define MASK_IDX 8'h0a
`define MODE_RST 8'h00
`define CTRL_RST 8'h00
`define STAT_RST 8'h00
`define MASK_RST 8'h00
`define COUNT_RST 16'h0000
`define SRC_MSB 7
`define SRC_LSB 5
`define DIV_MSB 4
`define DIV_LSB 3
`define ISEL_MSB 2
`define ISEL_LSB 0
`define EDGE_FALL_BIT 0
`define EV_BIT 0
`define ISEL_BASE 4'h8
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- wide_timer_pkg.sv ----
// Types shared by the wide timer and its clock source stage.
// Assumes wide_timer_cfg.svh for all numeric constants.
package wide_timer_pkg;
   typedef enum logic [2:0]
   {
      SRC_STOP = 3'b000,
      SRC_SYS = 3'b001,
      SRC_RSVD = 3'b010,
      SRC_PIN4_F = 3'b011,
      SRC_FAST = 3'b100,
      SRC_XTAL = 3'b101,
      SRC_SLOW = 3'b110,
      SRC_PIN0_F = 3'b111
   } clk_src_t;

   typedef enum logic [1:0]
   {
      DIV_1 = 2'b00,
      DIV_4 = 2'b01,
      DIV_16 = 2'b10,
      DIV_64 = 2'b11
   } prescale_t;

   typedef struct packed
   {
      logic [4:0] meta;
      logic [4:0] stab;
      logic [4:0] last;
      logic [5:0] pre;
      logic tick;
   } src_state_t;

   typedef struct packed
   {
      logic [7:0] mode;
      logic [7:0] ctrl;
      logic [7:0] status;
      logic [7:0] mask;
      logic [15:0] count;
      logic arm_rise;
      logic aw_held;
      logic [7:0] aw_idx;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } timer_state_t;
endpackage

// ---- tick_if.sv ----
// Carries source and divider choice out, and the prescaled count tick back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface tick_if;
   wide_timer_pkg::clk_src_t src;
   wide_timer_pkg::prescale_t div;
   logic tick;
   modport producer (input src, input div, output tick);
   modport consumer (output src, output div, input tick);
endinterface
`default_nettype wire

// ---- clk_source_sel.sv ----
// Count clock source selection, pin synchronisers and prescaler.
// Assumes oscillator inputs are levels much slower than the clock.
`timescale 1ns/1ns
`default_nettype none
`include "wide_timer_cfg.svh"
module clk_source_sel
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic fast_internal_osc,
   input wire logic crystal_osc,
   input wire logic slow_internal_osc,
   input wire logic port_a_pin4,
   input wire logic port_a_pin0,
   tick_if.producer tk
);
   wide_timer_pkg::src_state_t st_r;
   wide_timer_pkg::src_state_t st_nxt;
   logic raw;

   function automatic logic [5:0] div_limit(input wide_timer_pkg::prescale_t d);
      case (d)
         wide_timer_pkg::DIV_1: div_limit = 6'h00;
         wide_timer_pkg::DIV_4: div_limit = 6'h03;
         wide_timer_pkg::DIV_16: div_limit = 6'h0f;
         default: div_limit = 6'h3f;
      endcase
   endfunction

   always_comb
   begin
      st_nxt = st_r;
      // Order: fast, crystal, slow, pin4, pin0; meta feeds stab only
      st_nxt.meta = {port_a_pin0, port_a_pin4, slow_internal_osc, crystal_osc, fast_internal_osc};
      st_nxt.stab = st_r.meta;
      st_nxt.last = st_r.stab;
      case (tk.src)
         wide_timer_pkg::SRC_SYS: raw = 1'b1;
         wide_timer_pkg::SRC_PIN4_F: raw = st_r.last[3] & ~st_r.stab[3];
         wide_timer_pkg::SRC_FAST: raw = ~st_r.last[0] & st_r.stab[0];
         wide_timer_pkg::SRC_XTAL: raw = ~st_r.last[1] & st_r.stab[1];
         wide_timer_pkg::SRC_SLOW: raw = ~st_r.last[2] & st_r.stab[2];
         wide_timer_pkg::SRC_PIN0_F: raw = st_r.last[4] & ~st_r.stab[4];
         default: raw = 1'b0;
      endcase
      st_nxt.tick = 1'b0;
      if (tk.src == wide_timer_pkg::SRC_STOP || tk.src == wide_timer_pkg::SRC_RSVD)
      begin
         st_nxt.pre = 6'h00;
      end
      else if (raw)
      begin
         // Prescaler counts source edges
         if (st_r.pre >= div_limit(tk.div))
         begin
            st_nxt.pre = 6'h00;
            st_nxt.tick = 1'b1;
         end
         else
         begin
            st_nxt.pre = st_r.pre + 6'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign tk.tick = st_r.tick;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   chk_stop_silent: assert property ($past(tk.src) == wide_timer_pkg::SRC_STOP |-> !tk.tick)
      else $error("tick while stopped");
   chk_sys_div1: assert property ((tk.src == wide_timer_pkg::SRC_SYS && tk.div == wide_timer_pkg::DIV_1)
      [*2] |-> tk.tick)
      else $error("divide by one missed a tick");
   chk_div4_gap: assert property ((tk.tick && tk.src == wide_timer_pkg::SRC_SYS
      && tk.div == wide_timer_pkg::DIV_4) ##1 $stable(tk.div) |-> !tk.tick [*3])
      else $error("divide by four ticked early");
   chk_pin_fall: assert property ((tk.src == wide_timer_pkg::SRC_PIN4_F && tk.div == wide_timer_pkg::DIV_1
      && st_r.last[3] && !st_r.stab[3]) |=> tk.tick)
      else $error("pin falling edge not counted");
endmodule
`default_nettype wire

// ---- wide_timer.sv ----
// Sixteen-bit interval timer with AXI4-Lite registers and a level interrupt.
// Assumes a single clock; source inputs are handled by clk_source_sel.
`timescale 1ns/1ns
`default_nettype none
`include "wide_timer_cfg.svh"
module wide_timer
#(
   parameter int ADDR_W = 12
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic fast_internal_osc,
   input wire logic crystal_osc,
   input wire logic slow_internal_osc,
   input wire logic port_a_pin4,
   input wire logic port_a_pin0,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);
   if (ADDR_W < 10)
   begin : g_bad_addr
      $error("ADDR_W must be at least 10");
   end

   wide_timer_pkg::timer_state_t st_r;
   wide_timer_pkg::timer_state_t st_nxt;
   tick_if tk ();

   logic aw_go;
   logic w_go;
   logic ar_go;
   logic wr_go;
   logic cnt_wr;
   logic [7:0] ar_idx;
   logic [15:0] inc;
   logic [3:0] bit_pos;
   logic old_bit;
   logic new_bit;
   logic step;
   logic ev;
   logic edge_fall;

   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      reg_index = a[9:2];
   endfunction

   function automatic logic is_mapped(input logic [7:0] idx);
      is_mapped = idx == `MODE_IDX || idx == `COUNT_IDX || idx == `CTRL_IDX
         || idx == `STAT_IDX || idx == `MASK_IDX;
   endfunction

   function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [7:0] nw, input logic en);
      byte_merge = en ? nw : old;
   endfunction

   clk_source_sel u_src
   (
      .clock(clock),
      .rst_n(rst_n),
      .fast_internal_osc(fast_internal_osc),
      .crystal_osc(crystal_osc),
      .slow_internal_osc(slow_internal_osc),
      .port_a_pin4(port_a_pin4),
      .port_a_pin0(port_a_pin0),
      .tk(tk.producer)
   );

   assign tk.src = wide_timer_pkg::clk_src_t'(st_r.mode[`SRC_MSB:`SRC_LSB]);
   assign tk.div = wide_timer_pkg::prescale_t'(st_r.mode[`DIV_MSB:`DIV_LSB]);

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshakes

   assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
   assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
   assign s_axi_arready = !st_r.rvalid;
   assign aw_go = s_axi_awvalid && s_axi_awready;
   assign w_go = s_axi_wvalid && s_axi_wready;
   assign ar_go = s_axi_arvalid && s_axi_arready;
   assign ar_idx = reg_index(s_axi_araddr);
   assign wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
   // Store instruction path into the counter
   assign cnt_wr = wr_go && st_r.aw_idx == `COUNT_IDX && st_r.wstrb[1:0] != 2'b00;

   ////////////////////////////////////////////////////////////////////////////
   // Count step and bit event

   assign edge_fall = st_r.ctrl[`EDGE_FALL_BIT];
   assign inc = st_r.count + 16'h0001;
   assign bit_pos = `ISEL_BASE + {1'b0, st_r.mode[`ISEL_MSB:`ISEL_LSB]};
   assign old_bit = st_r.count[bit_pos];
   assign new_bit = inc[bit_pos];
   assign step = tk.tick && !cnt_wr;

   always_comb
   begin
      ev = 1'b0;
      if (step && old_bit != new_bit)
      begin
         if (st_r.arm_rise || !edge_fall)
         begin
            ev = new_bit;
         end
         else
         begin
            ev = !new_bit;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      st_nxt = st_r;
      if (aw_go)
      begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_idx = reg_index(s_axi_awaddr);
      end
      if (w_go)
      begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end
      if (step)
      begin
         st_nxt.count = inc;
         if (new_bit && !old_bit)
         begin
            st_nxt.arm_rise = 1'b0;
         end
      end
      if (wr_go)
      begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = is_mapped(st_r.aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
         case (st_r.aw_idx)
            `MODE_IDX: st_nxt.mode = byte_merge(st_r.mode, st_r.wdata[7:0], st_r.wstrb[0]);
            `COUNT_IDX:
            begin
               // Restart: edge history dropped, wait for zero-to-one
               // Unstrobed bytes keep their value; the step only lands when neither byte is strobed
               st_nxt.count[7:0] = byte_merge(st_nxt.count[7:0], st_r.wdata[7:0], st_r.wstrb[0]);
               st_nxt.count[15:8] = byte_merge(st_nxt.count[15:8], st_r.wdata[15:8], st_r.wstrb[1]);
               if (cnt_wr)
               begin
                  st_nxt.arm_rise = 1'b1;
               end
            end
            `CTRL_IDX: st_nxt.ctrl = byte_merge(st_r.ctrl, {7'h00, st_r.wdata[0]}, st_r.wstrb[0]);
            `MASK_IDX: st_nxt.mask = byte_merge(st_r.mask, {7'h00, st_r.wdata[0]}, st_r.wstrb[0]);
            default: st_nxt.bresp = st_nxt.bresp;
         endcase
      end
      if (st_r.bvalid && s_axi_bready)
      begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.rvalid && s_axi_rready)
      begin
         st_nxt.rvalid = 1'b0;
      end
      if (ar_go)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = is_mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
         case (ar_idx)
            `MODE_IDX: st_nxt.rdata = {24'h000000, st_r.mode};
            `COUNT_IDX: st_nxt.rdata = {16'h0000, st_r.count};
            `CTRL_IDX: st_nxt.rdata = {24'h000000, st_r.ctrl};
            `STAT_IDX: st_nxt.rdata = {24'h000000, st_r.status};
            `MASK_IDX: st_nxt.rdata = {24'h000000, st_r.mask};
            default: st_nxt.rdata = 32'h00000000;
         endcase
         if (ar_idx == `STAT_IDX)
         begin
            st_nxt.status = `STAT_RST;
         end
      end
      // Set wins over a read clear in the same cycle
      if (ev)
      begin
         st_nxt.status[`EV_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
         st_r.mode <= `MODE_RST;
         st_r.ctrl <= `CTRL_RST;
         st_r.status <= `STAT_RST;
         st_r.mask <= `MASK_RST;
         st_r.count <= `COUNT_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign irq = |(st_r.status & st_r.mask);

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence rise_step;
      step && !old_bit && new_bit;
   endsequence

   sequence fall_step;
      step && old_bit && !new_bit;
   endsequence

   chk_count_step: assert property (step |=> st_r.count == $past(st_r.count) + 16'h0001)
      else $error("counter did not step by one");
   chk_count_hold: assert property (!tk.tick && !wr_go |=> $stable(st_r.count))
      else $error("counter moved without a tick");
   chk_count_load: assert property (cnt_wr && st_r.wstrb[1:0] == 2'b11
      |=> st_r.count == $past(st_r.wdata[15:0]))
      else $error("count load lost");
   chk_count_read: assert property (ar_go && ar_idx == `COUNT_IDX
      |=> st_r.rvalid && st_r.rdata == {16'h0000, $past(st_r.count)})
      else $error("count readback wrong");
   chk_rise_fire: assert property (rise_step and (!edge_fall || st_r.arm_rise)
      |=> st_r.status[`EV_BIT])
      else $error("rising edge event missed");
   chk_fall_fire: assert property (fall_step and (edge_fall && !st_r.arm_rise)
      |=> st_r.status[`EV_BIT])
      else $error("falling edge event missed");
   chk_wrong_edge: assert property (fall_step and !edge_fall |-> !ev)
      else $error("event on unselected edge");
   chk_sel_bit: assert property (ev |-> step && st_r.count[bit_pos] != inc[bit_pos])
      else $error("event without selected bit change");
   chk_restart_arm: assert property (cnt_wr |=> st_r.arm_rise)
      else $error("restart kept old edge history");
   chk_armed_fall: assert property (st_r.arm_rise && step && old_bit && !new_bit |-> !ev)
      else $error("falling edge fired before rearm");
   chk_irq_follow: assert property (ev && st_r.mask[`EV_BIT] |=> irq)
      else $error("unmasked event gave no interrupt");
   chk_read_clear: assert property (ar_go && ar_idx == `STAT_IDX && !ev |=> st_r.status == `STAT_RST)
      else $error("status read did not clear");
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the wide timer: registers, sources, prescaler, events.
// Assumes the design files and wide_timer_cfg.svh are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "wide_timer_cfg.svh"
module tb;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rd_exp_t;
   localparam int LIMIT = 30000;
   logic clock = 0, rst_n = 0, osc_lvl = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [2:0] awprot = 0, arprot = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata, seed = 32'hb9fbafba;
   logic [3:0] wstrb = 0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   int failures = 0, n_tests = 0, cyc = 0;
   rd_exp_t rq[$];
   logic [1:0] bq[$];
   rd_exp_t e;

   // Pins idle high and fall as the oscillators rise
   wide_timer dut_u (.clock(clock), .rst_n(rst_n), .fast_internal_osc(osc_lvl), .crystal_osc(osc_lvl),
      .slow_internal_osc(osc_lvl), .port_a_pin4(~osc_lvl), .port_a_pin0(~osc_lvl),
      .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

   initial
   begin
      forever #4 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic cmp_val(input string nm, input logic [31:0] ex, input logic [31:0] sn);
      n_tests++;
      if (sn !== ex)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, sn);
      end
   endtask

   task automatic cmp_lvl(input string nm, input logic ex, input logic sn);
      n_tests++;
      if (sn !== ex)
      begin
         failures++;
         $display("[FAIL] %s expected %b seen %b", nm, ex, sn);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Response watcher and hang guard
   always @(posedge clock)
   begin
      if (rvalid === 1'b1 && rready)
      begin
         if (rq.size() == 0)
         begin
            failures++;
            $display("[FAIL] read note expected queued seen none");
         end
         e = rq.pop_front();
         cmp_val("read data", e.d, rdata & e.m);
         cmp_val("read resp", {30'h0, e.r}, {30'h0, rresp});
      end
      if (bvalid === 1'b1 && bready)
      begin
         if (bq.size() == 0)
         begin
            failures++;
            $display("[FAIL] write note expected queued seen none");
         end
         cmp_val("write resp", {30'h0, bq.pop_front()}, {30'h0, bresp});
      end
      cyc++;
      if (cyc == LIMIT)
      begin
         failures++;
         $display("[FAIL] run time expected below %0d seen %0d", LIMIT, cyc);
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s = 4'h1,
      input logic [1:0] er = `RESP_OKAY);
      logic a_ok, w_ok, a_dn, w_dn, b_ok;
      logic [31:0] t;
      a_dn = 0;
      w_dn = 0;
      b_ok = 0;
      t = rnd();
      bq.push_back(er);
      awaddr <= {2'b00, idx, 2'b00};
      awprot <= t[2:0];
      wdata <= d;
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(a_dn && w_dn))
      begin
         @(negedge clock);
         a_ok = awvalid && awready;
         w_ok = wvalid && wready;
         @(posedge clock);
         if (a_ok)
            awvalid <= 0;
         if (w_ok)
            wvalid <= 0;
         a_dn = a_dn || a_ok;
         w_dn = w_dn || w_ok;
      end
      while (!b_ok)
      begin
         @(negedge clock);
         b_ok = bvalid;
         @(posedge clock);
      end
      bready <= 0;
      @(posedge clock);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] ex, input logic [31:0] m = 32'hffffffff,
      input logic [1:0] er = `RESP_OKAY);
      logic a_ok, r_ok;
      logic [31:0] t;
      a_ok = 0;
      r_ok = 0;
      t = rnd();
      rq.push_back('{ex & m, m, er});
      araddr <= {2'b00, idx, 2'b00};
      arprot <= t[2:0];
      arvalid <= 1;
      rready <= 1;
      while (!a_ok)
      begin
         @(negedge clock);
         a_ok = arready;
         @(posedge clock);
      end
      arvalid <= 0;
      while (!r_ok)
      begin
         @(negedge clock);
         r_ok = rvalid;
         @(posedge clock);
      end
      rready <= 0;
      @(posedge clock);
   endtask

   task automatic chk_irq(input logic ex);
      @(negedge clock);
      cmp_lvl("irq", ex, irq);
      @(posedge clock);
   endtask

   task automatic wait_irq(input int n);
      int i;
      i = 0;
      do
      begin
         @(negedge clock);
         i++;
      end
      while (irq !== 1'b1 && i < n);
      cmp_lvl("irq raised", 1'b1, irq);
      @(posedge clock);
   endtask

   // Equal numbers of oscillator rises and pin falls
   task automatic pulse_src(input int n);
      repeat (n)
      begin
         osc_lvl <= 1;
         repeat (4) @(posedge clock);
         osc_lvl <= 0;
         repeat (4) @(posedge clock);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      int srcs[7];
      logic [2:0] src;
      logic [1:0] dv;
      logic [31:0] r;
      srcs = '{0, 2, 3, 4, 5, 6, 7};
      repeat (6) @(posedge clock);
      rst_n <= 1;
      @(posedge clock);
      rd(`MODE_IDX, 32'h0);
      rd(`COUNT_IDX, 32'h0);
      rd(`CTRL_IDX, 32'h0);
      rd(`STAT_IDX, 32'h0);
      rd(`MASK_IDX, 32'h0);
      chk_irq(0);
      $display("test reset values done");
      r = rnd();
      wr(`MODE_IDX, r);
      rd(`MODE_IDX, {24'h0, r[7:0]});
      wr(`MODE_IDX, 32'h0);
      wr(`COUNT_IDX, r, 4'h3);
      rd(`COUNT_IDX, {16'h0, r[15:0]});
      wr(`STAT_IDX, 32'hff);
      rd(`STAT_IDX, 32'h0);
      wr(8'hff, r, 4'hf, `RESP_SLVERR);
      rd(8'hff, 32'h0, 32'hffffffff, `RESP_SLVERR);
      $display("test register access done");
      for (int i = 0; i < 7; i++)
      begin
         src = srcs[i][2:0];
         dv = i[1:0];
         wr(`MODE_IDX, 32'h0);
         wr(`COUNT_IDX, 32'h0, 4'h3);
         wr(`MODE_IDX, {24'h0, src, dv, 3'b000});
         pulse_src(64);
         repeat (10) @(posedge clock);
         wr(`MODE_IDX, 32'h0);
         rd(`COUNT_IDX, (src == 0 || src == 2) ? 32'h0 : 32'd64 >> (2 * dv));
      end
      $display("test sources and prescaler done");
      wr(`MASK_IDX, 32'h1);
      for (int k = 0; k < 8; k++)
      begin
         wr(`MODE_IDX, 32'h0);
         wr(`COUNT_IDX, (32'h1 << (8 + k)) - 4, 4'h3);
         wr(`MODE_IDX, {24'h0, 3'b001, k[1:0], k[2:0]});
         wait_irq(400);
         wr(`MODE_IDX, 32'h0);
         rd(`COUNT_IDX, 32'h1 << (8 + k), 32'hff00);
         wr(`MASK_IDX, 32'h0);
         chk_irq(0);
         wr(`MASK_IDX, 32'h1);
         chk_irq(1);
         rd(`STAT_IDX, 32'h1, 32'hff);
         chk_irq(0);
      end
      $display("test bit select done");
      wr(`COUNT_IDX, 32'hf8, 4'h3);
      wr(`MODE_IDX, 32'h20);
      wait_irq(100);
      rd(`STAT_IDX, 32'h1, 32'hff);
      wait_irq(700);
      wr(`MODE_IDX, 32'h0);
      rd(`COUNT_IDX, 32'h300, 32'hff00);
      rd(`STAT_IDX, 32'h1, 32'hff);
      $display("test rising interval done");
      wr(`CTRL_IDX, 32'h1);
      rd(`CTRL_IDX, 32'h1, 32'hff);
      wr(`COUNT_IDX, 32'hf8, 4'h3);
      for (int j = 0; j < 3; j++)
      begin
         wr(`MODE_IDX, 32'h20);
         wait_irq(700);
         wr(`MODE_IDX, 32'h0);
         rd(`COUNT_IDX, (j == 0) ? 32'h100 : 32'h200 << (j - 1), 32'hff00);
         rd(`STAT_IDX, 32'h1, 32'hff);
      end
      $display("test falling interval done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
